// ---- rsfs_params.svh ----
/*
 * constants of the radar sample frame scheduler: timing, frame layout, rates, window seed.
 * assumes it is included by bare name by the package and the design modules.
 */
`ifndef RSFS_PARAMS_SVH
`define RSFS_PARAMS_SVH

// ==========================================================
// clocks and timing
`define RSFS_CLK_HZ      10000000
`define RSFS_ADC_CLK_HZ  500000
`define RSFS_IQ_GAP_NS   2000
`define RSFS_WIN_TIME_NS 300000

// ==========================================================
// frame and sample layout
`define RSFS_FRAME_LEN   256
`define RSFS_ADC_BITS    12
`define RSFS_SAMP_SHIFT  4
`define RSFS_GAIN_MAX    4

// ==========================================================
// sample rates in millihertz and their rate codes
`define RSFS_RATE_STEP_MHZ 1280000
`define RSFS_RATE_09_MHZ   11254000
`define RSFS_RATE_0A_MHZ   22528000
`define RSFS_CODE_FIRST    4'h1
`define RSFS_CODE_STEP_END 4'h8
`define RSFS_CODE_09       4'h9
`define RSFS_CODE_0A       4'hA

// ==========================================================
// hanning seed, q16: 2*cos(2pi/256) and cos(2pi/256)
`define RSFS_COS_K2      131033
`define RSFS_COS_ONE     65536
`define RSFS_COS_FIRST   65516

`endif

// ---- rsfs_pkg.sv ----
/*
 * types of the radar sample frame scheduler.
 * assumes rsfs_params.svh sits in the same folder.
 */
`include "rsfs_params.svh"

package rsfs_pkg;

    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_WAIT,
        ST_CONV_I,
        ST_CONV_Q,
        ST_WINDOW
    } rsfs_state_t;

    typedef logic signed [15:0] rsfs_samp_t;

endpackage : rsfs_pkg

// ---- rsfs_frame_buf.sv ----
/*
 * two-bank i/q frame store: one write port, one combinational read port for the
 * windowing pass, one registered read port for the downstream transform.
 * assumes writes and the combinational read come from one sequencer.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rsfs_params.svh"

module rsfs_frame_buf #(
    parameter int DEPTH = `RSFS_FRAME_LEN
) (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    // write port
    input  wire logic                      wr_en,
    input  wire logic                      wr_bank,
    input  wire logic [$clog2(DEPTH)-1:0]  wr_addr,
    input  wire rsfs_pkg::rsfs_samp_t      wr_i,
    input  wire rsfs_pkg::rsfs_samp_t      wr_q,
    // combinational read port
    input  wire logic                      ra_bank,
    input  wire logic [$clog2(DEPTH)-1:0]  ra_addr,
    output var rsfs_pkg::rsfs_samp_t       ra_i,
    output var rsfs_pkg::rsfs_samp_t       ra_q,
    // registered read port
    input  wire logic                      rb_bank,
    input  wire logic [$clog2(DEPTH)-1:0]  rb_addr,
    output var rsfs_pkg::rsfs_samp_t       rb_i,
    output var rsfs_pkg::rsfs_samp_t       rb_q
);

    typedef struct packed {
        logic [31:0] rd;
    } rsfs_buf_st_t;

    // ==========================================================
    // storage
    logic [31:0]  mem [2*DEPTH];
    rsfs_buf_st_t st;
    rsfs_buf_st_t next_st;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("frame depth must be a power of two");
    end

    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[{wr_bank, wr_addr}] <= {wr_i, wr_q};
    end

    assign ra_i = mem[{ra_bank, ra_addr}][31:16];
    assign ra_q = mem[{ra_bank, ra_addr}][15:0];

    // ==========================================================
    // registered port
    always_comb
    begin
        next_st    = st;
        next_st.rd = mem[{rb_bank, rb_addr}];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign rb_i = st.rd[31:16];
    assign rb_q = st.rd[15:0];

endmodule : rsfs_frame_buf
`default_nettype wire

// ---- rsfs_sched.sv ----
/*
 * radar sample frame scheduler: paces the i/q converter, fills 256-sample frames
 * into two banks, applies the hanning window in place and hands frames on.
 * assumes the converter answers each start with one adc_valid, in order, and
 * the downstream transform reads a finished bank before the next frame ends.
 */
// Behaviour
// - codes 01..08 sample at code times 1280 Hz.
// - code 09 samples at 11.254 kHz.
// - code 0A samples at 22.528 kHz.
// - exactly ten rate codes, up to 22.5 kHz.
// - frames hold 256 complex samples for a 256-point transform.
// - transform of a frame overlaps acquisition of the next.
// - only pause in sampling is the 300 us window calculation.
// - every frame is hanning-windowed before the transform.
// - i then q converted, q starting no more than 2 us later.
// - converter clocked at 500 kHz, 12-bit results per channel.
// - all sequencing runs from one internal clock.
// - front-end gain selectable from 1 to 16.
// - only one sensor input set sampled at a time.
// - direction information only in dual-channel operation.
// - 12-bit results shifted left four bits before processing.
`timescale 1ns/100ps
`default_nettype none
`include "rsfs_params.svh"

module rsfs_sched #(
    parameter int CLK_HZ = `RSFS_CLK_HZ
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // settings
    input  wire logic              sensor_input_select,
    input  wire logic [3:0]        sample_rate_code,
    input  wire logic [2:0]        gain_code,
    input  wire logic              single_channel,
    // converter and front end
    output logic                   adc_clk,
    output logic                   adc_start,
    output logic                   adc_chan,
    output logic                   adc_input_set,
    output logic [4:0]             pga_gain,
    input  wire logic              adc_valid,
    input  wire logic signed [11:0] adc_data,
    // downstream transform
    output logic                   frame_ready,
    output logic                   frame_bank,
    output logic                   dir_valid,
    output logic                   acq_paused,
    input  wire logic              proc_rd_bank,
    input  wire logic [7:0]        proc_rd_addr,
    output var rsfs_pkg::rsfs_samp_t proc_rd_i,
    output var rsfs_pkg::rsfs_samp_t proc_rd_q
);

    // ==========================================================
    // derived counts
    localparam int ADC_HALF = CLK_HZ / (2 * `RSFS_ADC_CLK_HZ);
    localparam int IQ_DLY   = int'((longint'(CLK_HZ) * `RSFS_IQ_GAP_NS) / 1000000000);
    localparam int WIN_CYC  = int'((longint'(CLK_HZ) * `RSFS_WIN_TIME_NS) / 1000000000);

    initial
    begin
        if (ADC_HALF < 1 || IQ_DLY < 1 || WIN_CYC < `RSFS_FRAME_LEN + 1 || WIN_CYC > 4095)
            $error("core clock cannot serve converter, i/q gap or window timing");
        if (ADC_HALF > 256 || IQ_DLY > 255)
            $error("core clock too fast for the converter clock or i/q gap counters");
        if ((longint'(CLK_HZ) * 1000) / `RSFS_RATE_STEP_MHZ > 65535)
            $error("core clock too fast for the sample timer");
    end

    typedef struct packed {
        rsfs_pkg::rsfs_state_t state;
        logic [15:0]           tmr;
        logic [7:0]            iq_cnt;
        logic [7:0]            div;
        logic                  adc_clk;
        logic                  adc_start;
        logic                  adc_chan;
        logic                  sens;
        logic [4:0]            gain;
        logic signed [15:0]    samp_i;
        logic [7:0]            idx;
        logic                  bank;
        logic [8:0]            win_idx;
        logic [11:0]           win_cnt;
        logic signed [19:0]    c_prev;
        logic signed [19:0]    c_cur;
        logic                  frame_ready;
        logic                  frame_bank;
        logic                  dir_valid;
    } rsfs_st_t;

    rsfs_st_t             st;
    rsfs_st_t             next_st;
    logic [15:0]          period;
    logic                 tick;
    logic                 wr_en;
    logic                 acq_we;
    logic [7:0]           wr_addr;
    rsfs_pkg::rsfs_samp_t wr_i;
    rsfs_pkg::rsfs_samp_t wr_q;
    rsfs_pkg::rsfs_samp_t ra_i;
    rsfs_pkg::rsfs_samp_t ra_q;
    rsfs_pkg::rsfs_samp_t shifted;
    logic signed [17:0]   win_w;
    logic signed [34:0]   prod_i;
    logic signed [34:0]   prod_q;
    logic signed [38:0]   c_prod;

    // ==========================================================
    // sample period per rate code; unknown codes fall back to the slowest rate
    function automatic logic [15:0] period_of(input logic [3:0] code);
        longint rate;
        rate = `RSFS_RATE_STEP_MHZ;
        if (code >= `RSFS_CODE_FIRST && code <= `RSFS_CODE_STEP_END)
            rate = longint'(code) * `RSFS_RATE_STEP_MHZ;
        else if (code == `RSFS_CODE_09)
            rate = `RSFS_RATE_09_MHZ;
        else if (code == `RSFS_CODE_0A)
            rate = `RSFS_RATE_0A_MHZ;
        return 16'((longint'(CLK_HZ) * 1000) / rate);
    endfunction : period_of

    assign period  = period_of(sample_rate_code);
    assign tick    = (st.tmr == 16'h0000);
    assign shifted = rsfs_pkg::rsfs_samp_t'(adc_data) <<< `RSFS_SAMP_SHIFT;

    // ==========================================================
    // hanning weight (1 - cos)/2 in q16, cosine by chebyshev recurrence
    assign win_w  = 18'((20'(`RSFS_COS_ONE) - st.c_cur) >>> 1);
    assign prod_i = ra_i * win_w;
    assign prod_q = ra_q * win_w;
    assign c_prod = 20'(`RSFS_COS_K2) * st.c_cur;

    always_comb
    begin
        acq_we  = (st.state == rsfs_pkg::ST_CONV_I && adc_valid && single_channel)
               || (st.state == rsfs_pkg::ST_CONV_Q && adc_valid);
        wr_en   = acq_we || (st.state == rsfs_pkg::ST_WINDOW && !st.win_idx[8]);
        wr_addr = acq_we ? st.idx : st.win_idx[7:0];
        if (acq_we)
        begin
            wr_i = (st.state == rsfs_pkg::ST_CONV_I) ? shifted : st.samp_i;
            wr_q = single_channel ? 16'sh0000 : shifted;
        end
        else
        begin
            wr_i = 16'(prod_i >>> 16);
            wr_q = 16'(prod_q >>> 16);
        end
    end

    // ==========================================================
    // sequencer
    always_comb
    begin
        next_st             = st;
        next_st.adc_start   = 1'b0;
        next_st.frame_ready = 1'b0;
        next_st.gain        = 5'(5'h01 << ((gain_code > 3'(`RSFS_GAIN_MAX))
                              ? 3'(`RSFS_GAIN_MAX) : gain_code));
        next_st.dir_valid   = !single_channel;
        // converter clock divider, free running
        if (st.div == 8'(ADC_HALF - 1))
        begin
            next_st.div     = 8'h00;
            next_st.adc_clk = !st.adc_clk;
        end
        else
            next_st.div = st.div + 8'h01;
        // the sample timer runs on during conversions so the rate holds
        if (st.state != rsfs_pkg::ST_WINDOW)
            next_st.tmr = tick ? period - 16'h0001 : st.tmr - 16'h0001;
        unique case (st.state)
            rsfs_pkg::ST_WAIT:
            begin
                if (tick)
                begin
                    if (st.idx == 8'h00)
                        next_st.sens = sensor_input_select;
                    next_st.adc_start = 1'b1;
                    next_st.adc_chan  = 1'b0;
                    next_st.iq_cnt    = 8'h00;
                    next_st.state     = rsfs_pkg::ST_CONV_I;
                end
            end
            rsfs_pkg::ST_CONV_I:
            begin
                // q start is timed from the i start, not from the i result
                if (!single_channel && st.iq_cnt == 8'(IQ_DLY - 1))
                begin
                    next_st.adc_start = 1'b1;
                    next_st.adc_chan  = 1'b1;
                end
                if (st.iq_cnt != 8'hFF)
                    next_st.iq_cnt = st.iq_cnt + 8'h01;
                if (adc_valid)
                    next_st.samp_i = shifted;
                if (adc_valid && !single_channel)
                    next_st.state = rsfs_pkg::ST_CONV_Q;
            end
            rsfs_pkg::ST_CONV_Q:
            begin
                if (st.iq_cnt == 8'(IQ_DLY - 1))
                begin
                    next_st.adc_start = 1'b1;
                    next_st.adc_chan  = 1'b1;
                end
                if (st.iq_cnt != 8'hFF)
                    next_st.iq_cnt = st.iq_cnt + 8'h01;
            end
            rsfs_pkg::ST_WINDOW:
            begin
                next_st.win_cnt = st.win_cnt + 12'h001;
                if (!st.win_idx[8])
                begin
                    next_st.win_idx = st.win_idx + 9'h001;
                    next_st.c_prev  = st.c_cur;
                    // rounded: a floored step biases the cosine and drifts the window
                    next_st.c_cur   = 20'((c_prod + 39'sd32768) >>> 16) - st.c_prev;
                end
                if (st.win_cnt == 12'(WIN_CYC - 1))
                begin
                    next_st.frame_ready = 1'b1;
                    next_st.frame_bank  = st.bank;
                    next_st.bank        = !st.bank;
                    next_st.tmr         = period - 16'h0001;
                    next_st.state       = rsfs_pkg::ST_WAIT;
                end
            end
        endcase
        if (acq_we)
        begin
            next_st.idx = st.idx + 8'h01;
            next_st.state = rsfs_pkg::ST_WAIT;
            if (st.idx == 8'(`RSFS_FRAME_LEN - 1))
            begin
                next_st.state   = rsfs_pkg::ST_WINDOW;
                next_st.win_idx = 9'h000;
                next_st.win_cnt = 12'h000;
                next_st.c_prev  = 20'(`RSFS_COS_FIRST);
                next_st.c_cur   = 20'(`RSFS_COS_ONE);
            end
        end
    end

    // one clock domain for all sequencing
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st       <= '0;
            st.state <= rsfs_pkg::ST_WAIT;
            st.gain  <= 5'h01;
        end
        else
            st <= next_st;
    end

    rsfs_frame_buf #(
        .DEPTH (`RSFS_FRAME_LEN)
    ) u_buf (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_en    (wr_en),
        .wr_bank  (st.bank),
        .wr_addr  (wr_addr),
        .wr_i     (wr_i),
        .wr_q     (wr_q),
        .ra_bank  (st.bank),
        .ra_addr  (st.win_idx[7:0]),
        .ra_i     (ra_i),
        .ra_q     (ra_q),
        .rb_bank  (proc_rd_bank),
        .rb_addr  (proc_rd_addr),
        .rb_i     (proc_rd_i),
        .rb_q     (proc_rd_q)
    );

    assign adc_clk       = st.adc_clk;
    assign adc_start     = st.adc_start;
    assign adc_chan      = st.adc_chan;
    assign adc_input_set = st.sens;
    assign pga_gain      = st.gain;
    assign frame_ready   = st.frame_ready;
    assign frame_bank    = st.frame_bank;
    assign dir_valid     = st.dir_valid;
    assign acq_paused    = (st.state == rsfs_pkg::ST_WINDOW);

    // ==========================================================
    // checks
    a_iq_gap: assert property (@(posedge core_clk) disable iff (!nrst)
        (adc_start && !adc_chan && !single_channel) |-> ##IQ_DLY (adc_start && adc_chan))
        else $error("q start not at the i/q gap");
    a_win_pause: assert property (@(posedge core_clk) disable iff (!nrst)
        acq_paused |-> !adc_start && !acq_we)
        else $error("sampling during window pause");
    a_win_len: assert property (@(posedge core_clk) disable iff (!nrst)
        frame_ready |-> $past(st.win_cnt) == 12'(WIN_CYC - 1))
        else $error("window pause length wrong");
    a_frame_end: assert property (@(posedge core_clk) disable iff (!nrst)
        (acq_we && st.idx == 8'hFF) |=> acq_paused && st.win_idx == 9'h000)
        else $error("frame end did not start windowing");
    a_bank_swap: assert property (@(posedge core_clk) disable iff (!nrst)
        frame_ready |-> (frame_bank != st.bank) && st.idx == 8'h00)
        else $error("bank not switched on frame hand-over");
    a_shift_in: assert property (@(posedge core_clk) disable iff (!nrst)
        acq_we |-> wr_i[3:0] == 4'h0 && wr_q[3:0] == 4'h0)
        else $error("sample not shifted by four");
    a_mono_q: assert property (@(posedge core_clk) disable iff (!nrst)
        (acq_we && single_channel) |-> wr_q == 16'sh0000 && !$past(adc_chan && adc_start))
        else $error("q used in single-channel mode");
    a_rate_reload: assert property (@(posedge core_clk) disable iff (!nrst)
        (tick && !acq_paused) |=> st.tmr == $past(period) - 16'h0001)
        else $error("sample timer reload wrong");
    a_gain_range: assert property (@(posedge core_clk) disable iff (!nrst)
        $onehot(pga_gain))
        else $error("gain outside 1 to 16");
    a_sensor_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (adc_start && st.idx != 8'h00) |-> $stable(adc_input_set))
        else $error("sensor set changed inside a frame");

endmodule : rsfs_sched
`default_nettype wire

// ---- rsfs_adc_model.sv ----
/*
 * behavioural dual-channel converter for the frame scheduler bench.
 * assumes conversion starts come at least two cycles apart.
 */
`timescale 1ns/100ps
`default_nettype none

module rsfs_adc_model (
    // clock
    input  wire logic               core_clk,
    // converter
    input  wire logic               adc_start,
    input  wire logic               adc_chan,
    input  wire logic [31:0]        lat,
    output logic                    adc_valid,
    output logic signed [11:0]      adc_data
);
    // ==========================================================
    // fixed results: i positive, q negative, so a swap shows up
    localparam logic signed [11:0] I_VAL = 12'h100;
    localparam logic signed [11:0] Q_VAL = 12'hF80;

    initial
    begin
        adc_valid = 1'b0;
        adc_data  = 12'hFFF;
    end

    // one 12-bit answer per start, in order, lat cycles later
    always @(posedge core_clk)
    begin
        if (adc_start)
        begin
            fork
                answer(adc_chan);
            join_none
        end
    end

    task automatic answer(input logic ch);
        int n;
        for (n = 0; n < lat; n++)
            @(posedge core_clk);
        adc_valid <= 1'b1;
        adc_data  <= ch ? Q_VAL : I_VAL;
        @(posedge core_clk);
        adc_valid <= 1'b0;
        // stale result is not left on the bus
        adc_data  <= ch ? ~Q_VAL : ~I_VAL;
    endtask : answer
endmodule : rsfs_adc_model
`default_nettype wire

// ---- radar_sample_frame_scheduler_test.sv ----
/*
 * self-checking bench for the radar sample frame scheduler.
 * assumes rsfs_adc_model answers every conversion start.
 */
`timescale 1ns/100ps
`default_nettype none

module radar_sample_frame_scheduler_test;
    // ==========================================================
    // scaled clock parameter: counts shrink tenfold to keep the run short
    localparam int CLK_HZ = 1000000;
    localparam int GAP    = CLK_HZ / 500000;
    localparam int WIN    = CLK_HZ * 3 / 10000;
    localparam int HALF   = CLK_HZ / 1000000;

    logic                 core_clk = 1'b0;
    logic                 nrst = 1'b0;
    logic                 sensor_input_select = 1'b0;
    logic [3:0]           sample_rate_code = 4'hA;
    logic [2:0]           gain_code = 3'h0;
    logic                 single_channel = 1'b0;
    logic                 proc_rd_bank = 1'b0;
    logic [7:0]           proc_rd_addr = 8'h00;
    logic [31:0]          lat = 32'h1;
    logic                 adc_clk, adc_start, adc_chan, adc_input_set, adc_valid;
    logic                 frame_ready, frame_bank, dir_valid, acq_paused;
    logic [4:0]           pga_gain;
    logic signed [11:0]   adc_data;
    rsfs_pkg::rsfs_samp_t proc_rd_i, proc_rd_q;
    int                   err_total = 0;
    int                   n_checks = 0;

    always #50 core_clk = ~core_clk;

    rsfs_sched #(.CLK_HZ(CLK_HZ)) DUT (
        .core_clk(core_clk), .nrst(nrst), .sensor_input_select(sensor_input_select),
        .sample_rate_code(sample_rate_code), .gain_code(gain_code),
        .single_channel(single_channel), .adc_clk(adc_clk), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_input_set(adc_input_set), .pga_gain(pga_gain),
        .adc_valid(adc_valid), .adc_data(adc_data), .frame_ready(frame_ready),
        .frame_bank(frame_bank), .dir_valid(dir_valid), .acq_paused(acq_paused),
        .proc_rd_bank(proc_rd_bank), .proc_rd_addr(proc_rd_addr),
        .proc_rd_i(proc_rd_i), .proc_rd_q(proc_rd_q));

    rsfs_adc_model adc (
        .core_clk(core_clk), .adc_start(adc_start), .adc_chan(adc_chan),
        .lat(lat), .adc_valid(adc_valid), .adc_data(adc_data));

    // ==========================================================
    // common tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
            err_total++;
        end
    endtask : check

    task automatic stop_test();
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    // second reset mid-run is covered too, so reset values are checked every time
    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check("pga_gain in reset", 5'h01, pga_gain);
        check("adc_start in reset", 0, adc_start);
        check("frame_ready in reset", 0, frame_ready);
        @(posedge core_clk);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic wait_start(input logic ch, output int cyc);
        cyc = 0;
        do
        begin
            @(negedge core_clk);
            cyc++;
        end
        while (!(adc_start === 1'b1 && adc_chan === ch) && cyc < 2000);
        if (cyc >= 2000)
            check("adc_start seen", 1, 0);
    endtask : wait_start

    // ==========================================================
    // scenarios
    task automatic clk_run();
        int k;
        logic prev;
        @(negedge core_clk);
        for (k = 0; k < 8; k++)
        begin
            prev = adc_clk;
            repeat (HALF) @(negedge core_clk);
            check("adc_clk toggle", !prev, adc_clk);
        end
    endtask : clk_run

    task automatic gain_run();
        int g;
        for (g = 0; g < 8; g++)
        begin
            @(posedge core_clk);
            gain_code <= g[2:0];
            repeat (2) @(negedge core_clk);
            check("pga_gain", 32'h1 << ((g > 4) ? 4 : g), pga_gain);
        end
    endtask : gain_run

    task automatic rate_run();
        int code, c;
        longint mhz;
        for (code = 1; code <= 10; code++)
        begin
            @(posedge core_clk);
            sample_rate_code <= code[3:0];
            mhz = (code <= 8) ? code * 1280000 : (code == 9) ? 11254000 : 22528000;
            wait_start(1'b0, c);
            wait_start(1'b0, c);
            wait_start(1'b0, c);
            check("sample period", longint'(CLK_HZ) * 1000 / mhz, c);
        end
    endtask : rate_run

    // slow converter answers i after the q start: gap must not move
    task automatic iq_run(input logic mono, input int l);
        int c, k, qat;
        @(posedge core_clk);
        single_channel <= mono;
        lat <= l;
        wait_start(1'b0, c);
        wait_start(1'b0, c);
        qat = -1;
        for (k = 1; k <= 40; k++)
        begin
            @(negedge core_clk);
            if (adc_start === 1'b1 && adc_chan === 1'b1)
                qat = k;
        end
        check("q start offset", mono ? -1 : GAP, qat);
        check("dir_valid", !mono, dir_valid);
    endtask : iq_run

    task automatic read_near(input int a, input int ei, input int eq);
        @(posedge core_clk);
        proc_rd_bank <= 1'b1;
        proc_rd_addr <= a[7:0];
        @(posedge core_clk);
        @(negedge core_clk);
        check("window i", 1, ($signed(proc_rd_i) - ei) inside {[-64:64]});
        check("window q", 1, ($signed(proc_rd_q) - eq) inside {[-64:64]});
    endtask : read_near

    task automatic frame_run(input logic bank);
        int n, c, s, first;
        n = 0;
        c = 0;
        first = 0;
        while (acq_paused !== 1'b1 && c < 20000)
        begin
            @(negedge core_clk);
            c++;
            if (adc_start === 1'b1 && adc_chan === 1'b0)
            begin
                n++;
                if (n == 1)
                    first = c;
            end
        end
        check("first start", 1, first <= 45);
        check("samples per frame", 256, n);
        check("adc_input_set", 1, adc_input_set);
        c = 0;
        s = 0;
        while (acq_paused === 1'b1 && c < 20000)
        begin
            if (adc_start === 1'b1)
                s++;
            c++;
            @(negedge core_clk);
        end
        check("pause length", WIN, c);
        check("starts in pause", 0, s);
        c = 0;
        while (frame_ready !== 1'b1 && c < 4)
        begin
            @(negedge core_clk);
            c++;
        end
        check("frame_ready", 1, frame_ready);
        check("frame_bank", bank, frame_bank);
        @(negedge core_clk);
        check("frame_ready pulse", 0, frame_ready);
        if (bank)
        begin
            read_near(0, 0, 0);
            read_near(64, 2048, -1024);
            read_near(128, 4096, -2048);
        end
    endtask : frame_run

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        do_reset();
        clk_run();
        gain_run();
        rate_run();
        iq_run(1'b0, 1);
        iq_run(1'b0, 5);
        iq_run(1'b1, 1);
        @(posedge core_clk);
        single_channel <= 1'b0;
        sensor_input_select <= 1'b1;
        lat <= 32'h1;
        do_reset();
        frame_run(1'b0);
        frame_run(1'b1);
        stop_test();
    end

    initial
    begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
endmodule : radar_sample_frame_scheduler_test
`default_nettype wire
